//--- logic/csq_pkg.sv
package csq_pkg;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MIN_RESET_CYC = 400;
  localparam int RATIO_SETTLE_CYC = 20;
  localparam int SROM_DIV = 126;
  localparam int SROM_HALF = SROM_DIV / 2;
  localparam int SYNC_STAGES = 3;
  // Geometry
  localparam int IRQ_W = 4;
  localparam int ADDR_W = 36;
  localparam int CMD_W = 4;
  localparam int FILL_BITS = 200;
  localparam int ICACHE_LINES = 256;
  localparam int CTL_W = 6;
  // Cache control output positions
  localparam int CTL_DATA_OE = 0;
  localparam int CTL_DATA_WE = 1;
  localparam int CTL_TAG_OE = 2;
  localparam int CTL_TAG_WE = 3;
  localparam int CTL_ST_CLK1 = 4;
  localparam int CTL_ST_CLK2 = 5;
  // Synchronised pin positions
  localparam int PIN_W = IRQ_W + 5;
  localparam int PIN_PG = IRQ_W + 4;
  localparam int PIN_RSTN = IRQ_W + 3;
  localparam int PIN_SROM_PRES_N = IRQ_W + 2;
  localparam int PIN_SROM_DATA = IRQ_W + 1;
  localparam int PIN_GRANT = IRQ_W;
  // Values
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_READ = 4'h1;
  localparam logic [ADDR_W-1:0] RESET_PC = 36'h0;
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 9'h000;

  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_TEST_WR = 7'h02,
    ST_TEST_RD = 7'h04,
    ST_FLUSH = 7'h08,
    ST_SROM = 7'h10,
    ST_DISPATCH = 7'h20,
    ST_RUN = 7'h40
  } csq_state_e;
endpackage

//--- logic/csq_pin_if.sv
interface csq_pin_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

//--- logic/csq_sync.sv
module csq_sync
  import csq_pkg::*;
#(
  parameter int W = PIN_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins
  csq_pin_if.sync pins
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // A change counts once the second and third stages agree
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign pins.clean = out_q;
endmodule

//--- logic/csq_boot_seq.sv
// Functional notes
// - Power good low forces internal reset regardless of the reset pin.
// - After release: cache self-test, optional serial load, then dispatch to address 0.
// - Without serial load, dispatch misses flushed caches and issues an off-chip read.
// - Reset release may be asynchronous; it is synchronised internally.
// - In reset, cache buses float and cache RAM strobes stay deasserted.
// - In reset, address bus driven or floated per grant at last rising sysclk edge.
// - In reset, command bus driven as no-op or floated per last sampled grant.
// - In reset, interrupt inputs are read as the sysclk divisor ratio.
// - Writing the flush control invalidates the whole instruction cache, except a line whose serial load completes in that same cycle.
// - Ring oscillator while power good low, input oscillator once high.
// - Power good low and reset asserted: all pins float with weak pull-down; the code floats only the address, command and cache buses.
// - Ratio change during reset yields correct sysclk within 20 cycles.
// - Internal reset held through self-test; result to status and test output.
module csq_boot_seq
  import csq_pkg::*;
#(
  parameter int LINES = ICACHE_LINES,
  parameter int FBITS = FILL_BITS,
  parameter int SDIV = SROM_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Board inputs
  input wire logic power_good,
  input wire logic sys_reset_n,
  input wire logic [IRQ_W-1:0] irq,
  input wire logic addr_bus_req,
  // Serial ROM
  input wire logic srom_present_n,
  input wire logic srom_data,
  output logic srom_oe_n,
  output logic srom_clk,
  // Core side
  input wire logic icache_flush_control_wr,
  input wire logic core_cache_bus_oe,
  input wire logic [CTL_W-1:0] core_cache_ctl,
  // Cache pins
  output logic cache_bus_oe,
  output logic [CTL_W-1:0] cache_ctl,
  // System bus
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [CMD_W-1:0] cmd_out,
  output logic cmd_par,
  output logic cmd_oe,
  // Clocking
  output logic clk_src_osc,
  output logic sysclk_out,
  output logic [IRQ_W-1:0] sysclk_ratio,
  output logic ratio_settled,
  // Status
  output logic pin_pulldown_en,
  output logic cpu_reset_int,
  output logic selftest_fail,
  output logic [1:0] test_status,
  output logic fetch_hit,
  output logic scache_flush
);
  localparam int IDX_W = $clog2(LINES);
  localparam int BIT_W = $clog2(FBITS + 1);
  localparam int DIV_W = $clog2(SDIV + 1);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(LINES - 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(FBITS - 1);
  localparam logic [DIV_W-1:0] LAST_DIV = DIV_W'(SDIV - 1);
  localparam logic [DIV_W-1:0] HALF_DIV = DIV_W'(SROM_HALF);
  localparam logic [4:0] SETTLE = 5'(RATIO_SETTLE_CYC);

  // Pin synchronisers
  csq_pin_if #(.W(PIN_W)) pif ();
  assign pif.raw = {power_good, sys_reset_n, srom_present_n, srom_data, addr_bus_req, irq};
  csq_sync #(.W(PIN_W), .RST_VAL(PIN_RST_VAL)) u_sync (
    .clk(clk),
    .srst(srst),
    .pins(pif)
  );

  logic pg_s, rstn_s, srom_pres_s, srom_data_s, grant_s;
  logic [IRQ_W-1:0] irq_s;
  assign pg_s = pif.clean[PIN_PG];
  assign rstn_s = pif.clean[PIN_RSTN];
  assign srom_pres_s = ~pif.clean[PIN_SROM_PRES_N];
  assign srom_data_s = pif.clean[PIN_SROM_DATA];
  assign grant_s = pif.clean[PIN_GRANT];
  assign irq_s = pif.clean[IRQ_W-1:0];

  logic ext_reset;
  assign ext_reset = ~pg_s | ~rstn_s;

  // Sequencer state
  csq_state_e state_q, state_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [BIT_W-1:0] bit_q, bit_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [FBITS-1:0] fill_q, fill_d;
  logic fail_q, fail_d;
  logic srom_sel_q, srom_sel_d;
  logic mem_we;
  logic [FBITS-1:0] mem_wdata;
  logic [FBITS-1:0] line_mem [LINES];
  logic [LINES-1:0] valid_q, valid_d;
  logic valid_clr, valid_set;
  logic hit_d, flush_d, read_d;
  logic [FBITS-1:0] pattern;

  assign pattern = {FBITS{idx_q[0]}} ^ FBITS'(idx_q);

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    bit_d = bit_q;
    div_d = div_q;
    fill_d = fill_q;
    fail_d = fail_q;
    srom_sel_d = srom_sel_q;
    mem_we = 1'b0;
    mem_wdata = pattern;
    valid_clr = icache_flush_control_wr;
    valid_set = 1'b0;
    hit_d = 1'b0;
    flush_d = 1'b0;
    read_d = 1'b0;
    case (state_q)
      ST_RESET: begin
        idx_d = '0;
        bit_d = '0;
        div_d = '0;
        srom_sel_d = srom_pres_s;
        if (!ext_reset) begin
          fail_d = 1'b0;
          state_d = ST_TEST_WR;
        end
      end
      ST_TEST_WR: begin
        mem_we = 1'b1;
        idx_d = idx_q + 1'b1;
        if (idx_q == LAST_IDX) begin
          state_d = ST_TEST_RD;
        end
      end
      ST_TEST_RD: begin
        if (line_mem[idx_q] != pattern) begin
          fail_d = 1'b1;
        end
        idx_d = idx_q + 1'b1;
        if (idx_q == LAST_IDX) begin
          state_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        valid_clr = 1'b1;
        flush_d = 1'b1;
        state_d = srom_sel_q ? ST_SROM : ST_DISPATCH;
      end
      ST_SROM: begin
        div_d = (div_q == LAST_DIV) ? '0 : div_q + 1'b1;
        if (div_q == LAST_DIV) begin
          fill_d = {fill_q[FBITS-2:0], srom_data_s};
          bit_d = bit_q + 1'b1;
          if (bit_q == LAST_BIT) begin
            bit_d = '0;
            mem_we = 1'b1;
            mem_wdata = {fill_q[FBITS-2:0], srom_data_s};
            valid_set = 1'b1;
            idx_d = idx_q + 1'b1;
            if (idx_q == LAST_IDX) begin
              state_d = ST_DISPATCH;
            end
          end
        end
      end
      ST_DISPATCH: begin
        if (valid_q[0]) begin
          hit_d = 1'b1;
          state_d = ST_RUN;
        end else if (grant_s) begin
          read_d = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (ext_reset) begin
      state_d = ST_RESET;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_valid
      always_comb begin
        if (valid_set && idx_q == IDX_W'(g)) begin
          valid_d[g] = 1'b1;
        end else if (valid_clr) begin
          valid_d[g] = 1'b0;
        end else begin
          valid_d[g] = valid_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (mem_we) begin
      line_mem[idx_q] <= mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_RESET;
      idx_q <= '0;
      bit_q <= '0;
      div_q <= '0;
      fill_q <= '0;
      fail_q <= 1'b0;
      srom_sel_q <= 1'b0;
      valid_q <= '0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      bit_q <= bit_d;
      div_q <= div_d;
      fill_q <= fill_d;
      fail_q <= fail_d;
      srom_sel_q <= srom_sel_d;
      valid_q <= valid_d;
    end
  end

  // Sysclk ratio and divider
  logic [IRQ_W-1:0] ratio_q, ratio_d, half;
  logic [IRQ_W-1:0] sdiv_q, sdiv_d;
  logic sclk_q, sclk_d, grant_q, grant_d;
  logic [4:0] settle_q, settle_d;

  assign half = (ratio_q == '0) ? IRQ_W'(1) : ratio_q;

  always_comb begin
    ratio_d = ratio_q;
    settle_d = (settle_q == '0) ? settle_q : settle_q - 1'b1;
    sdiv_d = sdiv_q + 1'b1;
    sclk_d = sclk_q;
    grant_d = grant_q;
    if (ext_reset && irq_s != ratio_q) begin
      ratio_d = irq_s;
      settle_d = SETTLE;
      sdiv_d = '0;
      sclk_d = 1'b0;
    end else if (sdiv_q + 1'b1 >= half) begin
      sdiv_d = '0;
      sclk_d = ~sclk_q;
      if (!sclk_q) begin
        grant_d = grant_s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ratio_q <= '0;
      settle_q <= '0;
      sdiv_q <= '0;
      sclk_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      settle_q <= settle_d;
      sdiv_q <= sdiv_d;
      sclk_q <= sclk_d;
      grant_q <= grant_d;
    end
  end

  // Registered pin outputs
  logic int_reset, float_all;
  logic [ADDR_W-1:0] addr_d;
  logic [CMD_W-1:0] cmd_d;
  logic addr_oe_d, cbus_oe_d;
  logic [CTL_W-1:0] ctl_d;
  logic srom_oe_n_d, srom_clk_d;

  // Held through the idle cycle in RESET too, so it never drops before self-test
  assign int_reset = ext_reset | (state_q == ST_RESET) | (state_q == ST_TEST_WR)
    | (state_q == ST_TEST_RD);
  assign float_all = ~pg_s & ext_reset;

  always_comb begin
    addr_d = RESET_PC;
    cmd_d = read_d ? CMD_READ : CMD_NOP;
    addr_oe_d = (grant_q | read_d) & ~float_all;
    cbus_oe_d = core_cache_bus_oe & ~int_reset;
    ctl_d = core_cache_ctl & {CTL_W{~int_reset}};
    srom_oe_n_d = ~(state_q == ST_SROM);
    srom_clk_d = (state_q == ST_SROM) && (div_q < HALF_DIV);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_out <= '0;
      cmd_out <= CMD_NOP;
      cmd_par <= 1'b0;
      addr_oe <= 1'b0;
      cmd_oe <= 1'b0;
      cache_bus_oe <= 1'b0;
      cache_ctl <= '0;
      srom_oe_n <= 1'b1;
      srom_clk <= 1'b0;
      pin_pulldown_en <= 1'b1;
      cpu_reset_int <= 1'b1;
      fetch_hit <= 1'b0;
      scache_flush <= 1'b0;
      clk_src_osc <= 1'b0;
    end else begin
      addr_out <= addr_d;
      cmd_out <= cmd_d;
      cmd_par <= ^{addr_d, cmd_d};
      addr_oe <= addr_oe_d;
      cmd_oe <= addr_oe_d;
      cache_bus_oe <= cbus_oe_d;
      cache_ctl <= ctl_d;
      srom_oe_n <= srom_oe_n_d;
      srom_clk <= srom_clk_d;
      pin_pulldown_en <= float_all;
      cpu_reset_int <= int_reset;
      fetch_hit <= hit_d;
      scache_flush <= flush_d;
      clk_src_osc <= pg_s;
    end
  end

  assign sysclk_out = sclk_q;
  assign sysclk_ratio = ratio_q;
  assign ratio_settled = (settle_q == '0);
  assign selftest_fail = fail_q;
  assign test_status = {1'b0, fail_q};
endmodule

//--- verif/csq_boot_monitor.sv
module csq_boot_monitor
  import csq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Board pins
  input wire logic power_good,
  input wire logic sys_reset_n,
  // Device outputs
  input wire logic cache_bus_oe,
  input wire logic [CTL_W-1:0] cache_ctl,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic addr_oe,
  input wire logic [CMD_W-1:0] cmd_out,
  input wire logic cmd_par,
  input wire logic cmd_oe,
  input wire logic clk_src_osc,
  input wire logic [IRQ_W-1:0] sysclk_ratio,
  input wire logic ratio_settled,
  input wire logic pin_pulldown_en,
  input wire logic cpu_reset_int,
  input wire logic selftest_fail,
  input wire logic [1:0] test_status,
  input wire logic fetch_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_pg_forces_rst: assert property (!power_good [*7] |-> cpu_reset_int)
    else $error("internal reset dropped while power low");
  a_osc_follow: assert property ($stable(power_good) [*7] |-> clk_src_osc == power_good)
    else $error("clock source does not follow power good");
  a_cache_gated: assert property (cpu_reset_int && $past(cpu_reset_int)
    |-> !cache_bus_oe && cache_ctl == '0)
    else $error("cache pins active in reset");
  a_nop_in_rst: assert property (cpu_reset_int |-> cmd_out == CMD_NOP)
    else $error("command not idle in reset");
  a_read_frame: assert property (cmd_out == CMD_READ |-> addr_oe && cmd_oe
    && addr_out == RESET_PC && cmd_par == ^{addr_out, cmd_out})
    else $error("bad read frame");
  a_read_once: assert property (cmd_out == CMD_READ |=> cmd_out == CMD_NOP)
    else $error("read held too long");
  a_oe_pair: assert property (cmd_oe == addr_oe)
    else $error("address and command enables differ");
  a_float_pdown: assert property (pin_pulldown_en [*2] |-> !addr_oe && !cmd_oe)
    else $error("bus driven while pulled down");
  a_ratio_settle: assert property ($changed(sysclk_ratio) |-> ##[1:22] ratio_settled)
    else $error("ratio did not settle");
  a_status_pins: assert property (test_status == {1'b0, selftest_fail})
    else $error("test status mismatch");
  a_boot_order: assert property ($fell(cpu_reset_int)
    |-> $past(power_good, 8) && $past(sys_reset_n, 8))
    else $error("boot left reset too early");

  c_read: cover property (cmd_out == CMD_READ);
  c_hit: cover property (fetch_hit);
  c_settle: cover property ($rose(ratio_settled));
endmodule

bind csq_boot_seq csq_boot_monitor i_mon (.clk, .srst, .power_good, .sys_reset_n,
  .cache_bus_oe, .cache_ctl, .addr_out, .addr_oe, .cmd_out, .cmd_par, .cmd_oe,
  .clk_src_osc, .sysclk_ratio, .ratio_settled, .pin_pulldown_en, .cpu_reset_int,
  .selftest_fail, .test_status, .fetch_hit);

//--- verif/csq_board.sv
module csq_board
  import csq_pkg::*;
#(
  parameter int HOLD = MIN_RESET_CYC
) (
  // Clock and control
  input wire logic clk,
  input wire logic pwr_on,
  input wire logic bad_order,
  input wire logic [IRQ_W-1:0] ratio_cfg,
  input wire logic grant_cfg,
  input wire logic rom_fit,
  input wire logic srom_oe_n,
  // Board pins
  output logic power_good,
  output logic sys_reset_n,
  output logic [IRQ_W-1:0] irq,
  output logic addr_bus_req,
  output logic srom_present_n,
  output logic srom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  initial begin
    {power_good, sys_reset_n, addr_bus_req, srom_data} = '0;
    irq = '0;
    srom_present_n = 1'b1;
  end

  // No acknowledge or fill strobes exist, so they stay idle
  always @(posedge clk) begin
    cnt <= pwr_on ? cnt + 1 : 0;
    power_good <= pwr_on && cnt > 8;
    sys_reset_n <= bad_order || (power_good && cnt > HOLD);
    irq <= ratio_cfg;
    addr_bus_req <= grant_cfg;
    srom_present_n <= !rom_fit;
    srom_data <= srom_oe_n ? !srom_data : 1'b1;
  end
endmodule

//--- verif/csq_boot_seq_test.sv
module csq_boot_seq_test
  import csq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, pwr_on = 0, bad_order = 0, grant_cfg = 0, rom_fit = 0;
  logic icache_flush_control_wr = 0, core_cache_bus_oe = 0, saw_fl = 0;
  logic [CTL_W-1:0] core_cache_ctl = '0, cache_ctl;
  logic [IRQ_W-1:0] ratio_cfg = '0, irq, sysclk_ratio;
  logic power_good, sys_reset_n, addr_bus_req, srom_present_n, srom_data, srom_oe_n;
  logic cache_bus_oe, addr_oe, cmd_par, cmd_oe, clk_src_osc, sysclk_out, ratio_settled;
  logic pin_pulldown_en, cpu_reset_int, selftest_fail, fetch_hit, scache_flush;
  logic [ADDR_W-1:0] addr_out;
  logic [CMD_W-1:0] cmd_out;
  logic [1:0] test_status;
  int err_total = 0, total_checks = 0;
  int exp_q[$];

  csq_board i_brd (.clk, .pwr_on, .bad_order, .ratio_cfg, .grant_cfg, .rom_fit,
    .srom_oe_n, .power_good, .sys_reset_n, .irq, .addr_bus_req, .srom_present_n, .srom_data);

  csq_boot_seq #(.LINES(4), .FBITS(8), .SDIV(4)) i_dut (.clk, .srst, .power_good,
    .sys_reset_n, .irq, .addr_bus_req, .srom_present_n, .srom_data, .srom_oe_n,
    .srom_clk(), .icache_flush_control_wr, .core_cache_bus_oe, .core_cache_ctl,
    .cache_bus_oe, .cache_ctl, .addr_out, .addr_oe, .cmd_out, .cmd_par, .cmd_oe,
    .clk_src_osc, .sysclk_out, .sysclk_ratio, .ratio_settled, .pin_pulldown_en,
    .cpu_reset_int, .selftest_fail, .test_status, .fetch_hit, .scache_flush);

  initial forever #5 clk = ~clk;

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Boot once; expect a read (1) or a cache hit (2) at dispatch
  task automatic boot(input logic fit, input int res);
    int i;
    i = 0;
    @(posedge clk);
    rom_fit <= fit;
    grant_cfg <= 1'b1;
    pwr_on <= 1'b1;
    exp_q.push_back(res);
    while (cpu_reset_int !== 1'b0 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    check(selftest_fail, 0);
    check(clk_src_osc, 1);
    while (exp_q.size() > 0 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    check(exp_q.size(), 0);
  endtask

  always @(posedge clk) begin
    core_cache_ctl <= CTL_W'($urandom);
    core_cache_bus_oe <= 1'($urandom);
  end

  // Result watcher
  always @(negedge clk) begin
    if (scache_flush === 1'b1) saw_fl = 1'b1;
    if (cmd_out === CMD_READ || fetch_hit === 1'b1) begin
      check(saw_fl, 1);
      saw_fl = 1'b0;
      check(fetch_hit === 1'b1 ? 2 : 1, exp_q.size() ? exp_q.pop_front() : 0);
    end
  end

  initial begin
    #50us;
    err_total++;
    wrap_up;
  end

  initial begin
    logic [IRQ_W-1:0] r;
    logic v;
    int n;
    void'($urandom(12));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(negedge clk);
    check(pin_pulldown_en, 1);
    check(clk_src_osc, 0);
    @(posedge clk) bad_order <= 1'b1;
    repeat (10) @(negedge clk);
    check(cpu_reset_int, 1);
    check(cache_ctl, 0);
    check(cache_bus_oe, 0);
    @(posedge clk) bad_order <= 1'b0;
    pwr_on <= 1'b1;
    repeat (3) begin
      r = IRQ_W'($urandom_range(15, 1));
      @(posedge clk) ratio_cfg <= r;
      repeat (30) @(negedge clk);
      check(sysclk_ratio, r);
      v = sysclk_out;
      while (sysclk_out === v) @(negedge clk);
      v = sysclk_out;
      n = 0;
      while (sysclk_out === v) begin
        @(negedge clk);
        n++;
      end
      check(n, r);
    end
    @(posedge clk) ratio_cfg <= 4'h1;
    grant_cfg <= 1'b1;
    repeat (12) @(negedge clk);
    check(addr_oe, 1);
    check(cmd_oe, 1);
    check(cmd_out, CMD_NOP);
    @(posedge clk) grant_cfg <= 1'b0;
    repeat (12) @(negedge clk);
    check(addr_oe, 0);
    boot(1'b0, 1);
    @(posedge clk) icache_flush_control_wr <= 1'b1;
    pwr_on <= 1'b0;
    @(posedge clk) icache_flush_control_wr <= 1'b0;
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    boot(1'b1, 2);
    @(posedge clk) pwr_on <= 1'b0;
    repeat (10) @(negedge clk);
    boot(1'b0, 1);
    wrap_up;
  end
endmodule
